// >>> hdl/mrr_ctrl.sv
// Controller side: AXI4-Lite slave that runs link accesses and drain cycles
`timescale 1ns/10ps
module mrr_ctrl
  import mrr_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        reset,
  mrr_link_if.ctrl         link,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  // ----------------------------------------------------------------
  // Sequencer: single access or status-X-Y read cycle
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {MRR_IDLE, MRR_ONE, MRR_ST, MRR_X, MRR_Y} mrr_state_type;
  mrr_state_type state_reg;
  logic [3:0]  aw_reg;
  logic [31:0] w_reg;
  logic        aw_have_reg, w_have_reg;
  logic [7:0]  status_reg, x_reg, y_reg, data_reg;
  logic        busy_reg;
  logic [7:0]  l_addr_reg, l_wdata_reg;
  logic        l_req_reg, l_write_reg;

  wire wr_go  = aw_have_reg & w_have_reg & ~s_axi_bvalid;
  wire cmd_wr = wr_go & (aw_reg == MRR_C_CMD);
  wire start  = cmd_wr & ~busy_reg & w_reg[MRR_CMD_GO];   // Go bit starts an access
  wire run_cycle = w_reg[MRR_CMD_CYCLE];                  // Selects a full read cycle

  // Write address and data capture
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      aw_have_reg   <= 1'b0;
      w_have_reg    <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bresp   <= MRR_RESP_OK;
      aw_reg        <= 4'h0;
      w_reg         <= 32'h0;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_reg        <= s_axi_awaddr;
        aw_have_reg   <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_reg        <= s_axi_wdata;
        w_have_reg   <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_reg == MRR_C_CMD) ? MRR_RESP_OK : MRR_RESP_ERR;
        aw_have_reg  <= 1'b0;
        w_have_reg   <= 1'b0;
      end
      if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Link sequencing: one request, wait for its one-cycle answer
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_reg   <= MRR_IDLE;
      busy_reg    <= 1'b0;
      l_req_reg   <= 1'b0;
      l_write_reg <= 1'b0;
      l_addr_reg  <= 8'h00;
      l_wdata_reg <= 8'h00;
      status_reg  <= 8'h00;
      x_reg       <= 8'h00;
      y_reg       <= 8'h00;
      data_reg    <= 8'h00;
    end else begin
      l_req_reg <= 1'b0;
      unique case (state_reg)
        MRR_IDLE: if (start) begin
          busy_reg  <= 1'b1;
          l_req_reg <= 1'b1;
          if (run_cycle) begin
            // Status first so the snapshot is frozen before X and Y
            state_reg   <= MRR_ST;
            l_write_reg <= 1'b0;
            l_addr_reg  <= MRR_ADDR_STATUS;
          end else begin
            state_reg   <= MRR_ONE;
            l_write_reg <= w_reg[MRR_CMD_WRITE];
            l_addr_reg  <= w_reg[7:0];
            l_wdata_reg <= w_reg[MRR_CMD_WD_LSB +: 8];
          end
        end
        MRR_ONE: if (link.ack) begin
          data_reg  <= link.rdata;
          busy_reg  <= 1'b0;
          state_reg <= MRR_IDLE;
        end
        MRR_ST: if (link.ack) begin
          status_reg <= link.rdata;
          l_req_reg  <= 1'b1;
          l_addr_reg <= MRR_ADDR_HDISP;
          state_reg  <= MRR_X;
        end
        MRR_X: if (link.ack) begin
          x_reg      <= link.rdata;
          l_req_reg  <= 1'b1;
          l_addr_reg <= MRR_ADDR_VDISP;
          state_reg  <= MRR_Y;
        end
        MRR_Y: if (link.ack) begin
          y_reg     <= link.rdata;
          busy_reg  <= 1'b0;
          state_reg <= MRR_IDLE;
        end
      endcase
    end
  end

  assign link.req   = l_req_reg;
  assign link.write = l_write_reg;
  assign link.addr  = l_addr_reg;
  assign link.wdata = l_wdata_reg;

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  wire [31:0] rd_mux = (s_axi_araddr == MRR_C_CMD)    ? 32'h0 :
                       (s_axi_araddr == MRR_C_STATUS) ? {23'h0, busy_reg, status_reg} :
                       (s_axi_araddr == MRR_C_DATA)   ? {8'h0, data_reg, y_reg, x_reg} :
                                                        32'h0;
  wire rd_ok = (s_axi_araddr == MRR_C_CMD) | (s_axi_araddr == MRR_C_STATUS) |
               (s_axi_araddr == MRR_C_DATA);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= MRR_RESP_OK;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_mux;
      s_axi_rresp   <= rd_ok ? MRR_RESP_OK : MRR_RESP_ERR;
    end else if (s_axi_rvalid & s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule // mrr_ctrl

// >>> hdl/mrr_device.sv
// Sensor side: motion accumulators, snapshot registers and frame statistics
// Notes on behaviour
// - Status read freezes both displacement values
// - Status reread drops unread snapshot
// - Controller reads status, X, Y in order
// - Wide accumulators; overflow sets sticky flag
// - Overflow clears after read, not full scale
// - Pending after overflow reports saturated byte
// - Controller repeats read cycles until drained; mrr_ctrl runs one cycle per Go command, the AXI master repeats
// - Flush write discards all accumulated motion
// - X byte, two's complement, clears on read
// - Y byte, two's complement, clears on read
// - Feature register holds count over four
// - No surface gives near zero features
// - Brightness register is sum high byte
// - Brightness stays within 0 to 221
// - Peak pixel six bits, top two zero
// - Setup resets 0x09, bit 7 zero
// - Status bits: motion 7, overflow 4, res 0
// - Motion flag set while data pending
// - Resolution bit one means lower resolution
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/10ps
module mrr_device
  import mrr_pkg::*;
#(
  parameter int ACC_W = MRR_ACC_W
) (
  input  wire logic                sys_clk,
  input  wire logic                reset,
  mrr_link_if.device               link,
  input  wire logic                move_valid,   // One motion sample per pulse
  input  wire logic signed [7:0]   move_x,
  input  wire logic signed [7:0]   move_y,
  input  wire logic                frame_done,   // Frame statistics strobe
  input  wire logic [9:0]          frame_features,
  input  wire logic [15:0]         frame_sum,
  input  wire logic [5:0]          frame_peak,
  output logic                     led_shutter,
  output logic                     self_test_start
);
  // ----------------------------------------------------------------
  // Accumulators and snapshot state
  // ----------------------------------------------------------------
  localparam logic signed [ACC_W-1:0] ACC_MAX = {1'b0, {(ACC_W-1){1'b1}}};
  localparam logic signed [ACC_W-1:0] ACC_MIN = {1'b1, {(ACC_W-1){1'b0}}};

  logic signed [ACC_W-1:0] acc_x_reg, acc_y_reg;
  logic [7:0] snap_x_reg, snap_y_reg;
  logic       overflow_reg;
  logic       read_since_ovf_reg;
  logic [7:0] setup_reg;
  logic [7:0] feature_reg, bright_reg, peak_reg;
  logic       ack_reg;
  logic [7:0] rdata_reg;

  // Saturate a wide accumulator to the reported byte
  function automatic logic [7:0] sat8(input logic signed [ACC_W-1:0] v);
    if (v > $signed({{(ACC_W-8){1'b0}}, MRR_POS_FULL}))
      return MRR_POS_FULL;
    else if (v < $signed({{(ACC_W-8){1'b1}}, MRR_NEG_FULL}))
      return MRR_NEG_FULL;
    else
      return v[7:0];
  endfunction

  // Add at one bit wider; the top two bits differ when the true sum left the range
  function automatic logic signed [ACC_W:0] add_wide(input logic signed [ACC_W-1:0] a,
                                                     input logic signed [7:0] d);
    add_wide = {a[ACC_W-1], a} + {{(ACC_W-7){d[7]}}, d};
  endfunction

  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  wire rd        = link.req & ~link.write;
  wire wr        = link.req & link.write;
  wire rd_status = rd & (link.addr == MRR_ADDR_STATUS);
  wire rd_x      = rd & (link.addr == MRR_ADDR_HDISP);
  wire rd_y      = rd & (link.addr == MRR_ADDR_VDISP);
  wire wr_setup  = wr & (link.addr == MRR_ADDR_SETUP);
  wire wr_flush  = wr & (link.addr == MRR_ADDR_FLUSH);

  // Motion input added to the accumulators, minus the snapshot on a status read
  wire [7:0] take_x = rd_status ? sat8(acc_x_reg) : 8'h00;
  wire [7:0] take_y = rd_status ? sat8(acc_y_reg) : 8'h00;
  wire signed [ACC_W-1:0] base_x = acc_x_reg - {{(ACC_W-8){take_x[7]}}, take_x};
  wire signed [ACC_W-1:0] base_y = acc_y_reg - {{(ACC_W-8){take_y[7]}}, take_y};
  wire signed [ACC_W:0] sum_x = add_wide(base_x, move_valid ? move_x : 8'sh00);
  wire signed [ACC_W:0] sum_y = add_wide(base_y, move_valid ? move_y : 8'sh00);
  wire ovf_x = sum_x[ACC_W] != sum_x[ACC_W-1];
  wire ovf_y = sum_y[ACC_W] != sum_y[ACC_W-1];
  wire signed [ACC_W-1:0] acc_x_next = ovf_x ? (sum_x[ACC_W] ? ACC_MIN : ACC_MAX)
                                             : sum_x[ACC_W-1:0];
  wire signed [ACC_W-1:0] acc_y_next = ovf_y ? (sum_y[ACC_W] ? ACC_MIN : ACC_MAX)
                                             : sum_y[ACC_W-1:0];
  wire at_full = (acc_x_reg == ACC_MAX) | (acc_x_reg == ACC_MIN)
               | (acc_y_reg == ACC_MAX) | (acc_y_reg == ACC_MIN);
  wire motion_pending_flag = (acc_x_reg != '0) | (acc_y_reg != '0) |
                             (snap_x_reg != 8'h00) | (snap_y_reg != 8'h00);

  // Status byte; reserved bits always read zero
  logic [7:0] status_byte;
  always_comb begin
    status_byte                  = 8'h00;
    status_byte[MRR_ST_MOTION]   = motion_pending_flag;
    status_byte[MRR_ST_OVERFLOW] = overflow_reg;
    status_byte[MRR_ST_RES]      = setup_reg[MRR_SU_RES];
  end

  // Read data multiplexer
  logic [7:0] rdata_next;
  always_comb begin
    unique case (link.addr)
      MRR_ADDR_STATUS:  rdata_next = status_byte;
      MRR_ADDR_HDISP:   rdata_next = snap_x_reg;
      MRR_ADDR_VDISP:   rdata_next = snap_y_reg;
      MRR_ADDR_FEATURE: rdata_next = feature_reg;
      MRR_ADDR_BRIGHT:  rdata_next = bright_reg;
      MRR_ADDR_PEAK:    rdata_next = peak_reg;
      MRR_ADDR_SETUP:   rdata_next = setup_reg;
      default:          rdata_next = 8'h00;
    endcase
  end

  // Frame statistics, clamped to documented ranges
  wire [9:0] feat_cl  = (frame_features > MRR_FEATURE_MAX) ? MRR_FEATURE_MAX : frame_features;
  wire [7:0] bright_n = (frame_sum[15:8] > MRR_BRIGHT_MAX) ? MRR_BRIGHT_MAX : frame_sum[15:8];

  // ----------------------------------------------------------------
  // Motion path
  // ----------------------------------------------------------------
  // Flush wins over motion arriving the same cycle; the write is the later intent
  always_ff @(posedge sys_clk) begin
    if (reset | wr_flush) begin
      acc_x_reg <= '0;
      acc_y_reg <= '0;
    end else begin
      acc_x_reg <= acc_x_next;
      acc_y_reg <= acc_y_next;
    end
  end

  // Snapshot: a status read overwrites any unread value
  always_ff @(posedge sys_clk) begin
    if (reset | wr_flush) begin
      snap_x_reg <= 8'h00;
      snap_y_reg <= 8'h00;
    end else if (rd_status) begin
      snap_x_reg <= take_x;
      snap_y_reg <= take_y;
    end else begin
      if (rd_x) snap_x_reg <= 8'h00;
      if (rd_y) snap_y_reg <= 8'h00;
    end
  end

  // Overflow: new overflow wins over the clear condition
  always_ff @(posedge sys_clk) begin
    if (reset | wr_flush) begin
      overflow_reg       <= 1'b0;
      read_since_ovf_reg <= 1'b0;
    end else if (ovf_x | ovf_y) begin
      overflow_reg       <= 1'b1;
      read_since_ovf_reg <= 1'b0;
    end else begin
      if (rd_x | rd_y) read_since_ovf_reg <= 1'b1;
      if (read_since_ovf_reg & ~at_full) overflow_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Setup, frame statistics and link answer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      setup_reg       <= MRR_SETUP_RESET;
      self_test_start <= 1'b0;
    end else begin
      // Bit 7 forced zero, reserved low bits kept
      if (wr_setup)
        setup_reg <= (link.wdata & MRR_SETUP_WMASK) | (setup_reg & ~MRR_SETUP_WMASK &
                     ~(8'h01 << MRR_SU_ZERO));
      self_test_start <= wr_setup & link.wdata[MRR_SU_TEST];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      feature_reg <= 8'h00;
      bright_reg  <= 8'h00;
      peak_reg    <= 8'h00;
    end else if (frame_done) begin
      feature_reg <= feat_cl[9:2];
      bright_reg  <= bright_n;
      peak_reg    <= {2'b00, frame_peak};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ack_reg     <= 1'b0;
      rdata_reg   <= 8'h00;
      led_shutter <= 1'b0;
    end else begin
      ack_reg     <= link.req;
      rdata_reg   <= rd ? rdata_next : 8'h00;
      led_shutter <= setup_reg[MRR_SU_LED];
    end
  end

  assign link.ack   = ack_reg;
  assign link.rdata = rdata_reg;
endmodule // mrr_device

// >>> hdl/mrr_link_if.sv
// Register access link between the readout device and its controller
`timescale 1ns/10ps
interface mrr_link_if;
  logic       req;    // One-cycle access request
  logic       write;  // 1 write, 0 read
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       ack;    // One-cycle answer, one cycle after req
  logic [7:0] rdata;
  modport device (input req, write, addr, wdata, output ack, rdata);
  modport ctrl   (output req, write, addr, wdata, input ack, rdata);
endinterface

// >>> hdl/mrr_pkg.sv
// Shared constants for the motion report readout ends
package mrr_pkg;
  // Register addresses
  localparam logic [7:0] MRR_ADDR_STATUS  = 8'h02;
  localparam logic [7:0] MRR_ADDR_HDISP   = 8'h03;
  localparam logic [7:0] MRR_ADDR_VDISP   = 8'h04;
  localparam logic [7:0] MRR_ADDR_FEATURE = 8'h05;
  localparam logic [7:0] MRR_ADDR_BRIGHT  = 8'h06;
  localparam logic [7:0] MRR_ADDR_PEAK    = 8'h07;
  localparam logic [7:0] MRR_ADDR_SETUP   = 8'h0a;
  localparam logic [7:0] MRR_ADDR_FLUSH   = 8'h12;
  // Status and setup fields
  localparam int MRR_ST_MOTION    = 7;
  localparam int MRR_ST_OVERFLOW  = 4;
  localparam int MRR_ST_RES       = 0;
  localparam int MRR_SU_ZERO      = 7;
  localparam int MRR_SU_LED       = 6;
  localparam int MRR_SU_TEST      = 5;
  localparam int MRR_SU_RES       = 4;
  localparam logic [7:0] MRR_SETUP_RESET = 8'h09;
  localparam logic [7:0] MRR_SETUP_WMASK = 8'h70;
  // Motion and frame figures
  localparam int MRR_ACC_W        = 16;
  localparam logic [7:0] MRR_POS_FULL = 8'h7f;
  localparam logic [7:0] MRR_NEG_FULL = 8'h80;
  localparam logic [9:0] MRR_FEATURE_MAX = 10'h2a4; // 169 * 4
  localparam logic [7:0] MRR_BRIGHT_MAX  = 8'hdd;   // 221
  localparam int MRR_PIXELS       = 900;
  // Controller register map (AXI4-Lite byte addresses)
  localparam logic [3:0] MRR_C_CMD    = 4'h0;
  localparam logic [3:0] MRR_C_STATUS = 4'h4;
  localparam logic [3:0] MRR_C_DATA   = 4'h8;
  // Controller command word fields
  localparam int MRR_CMD_GO     = 8;
  localparam int MRR_CMD_CYCLE  = 9;
  localparam int MRR_CMD_WRITE  = 10;
  localparam int MRR_CMD_WD_LSB = 16;
  localparam logic [1:0] MRR_RESP_OK  = 2'b00;
  localparam logic [1:0] MRR_RESP_ERR = 2'b10;
endpackage

// >>> testbench/motion_report_readout_tb.sv
// Bench joining controller and device, driving AXI and sensor inputs
`timescale 1ns/10ps
module motion_report_readout_tb
  import mrr_pkg::*;
;
  logic              sys_clk, reset, move_valid, frame_done, led_shutter, self_test_start;
  logic signed [7:0] move_x, move_y;
  logic [9:0]        frame_features;
  logic [15:0]       frame_sum, xy;
  logic [5:0]        frame_peak;
  logic [3:0]        awaddr, araddr;
  logic [31:0]       wdata, rdata, rd_word;
  logic [1:0]        bresp, rresp, last_resp;
  logic [7:0]        rd_byte, st;
  logic              awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready;
  int                n_errors = 0, checks_done = 0, test_pulses = 0;

  // ----------------------------
  // Both ends and the link check
  // ----------------------------
  mrr_link_if link ();
  // Narrow accumulators so that overflow is reached in a few moves
  mrr_device #(.ACC_W(9)) i_mrr_device (.sys_clk(sys_clk), .reset(reset), .link(link),
    .move_valid(move_valid), .move_x(move_x), .move_y(move_y), .frame_done(frame_done),
    .frame_features(frame_features), .frame_sum(frame_sum), .frame_peak(frame_peak),
    .led_shutter(led_shutter), .self_test_start(self_test_start));
  mrr_ctrl i_mrr_ctrl (.sys_clk(sys_clk), .reset(reset), .link(link),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  mrr_link_assertions i_mrr_link_assertions (.sys_clk(sys_clk), .reset(reset),
    .req(link.req), .write(link.write), .addr(link.addr), .wdata(link.wdata),
    .ack(link.ack), .rdata(link.rdata));

  // Clock, and a pulse counter sampled away from the launching edge
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(negedge sys_clk) if (self_test_start === 1'b1) test_pulses++;

  // -------------
  // Shared tasks
  // -------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Ready is looked at on the falling edge, so the take edge is the next rising one
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    fork
      begin
        do @(negedge sys_clk); while (awready !== 1'b1);
        @(posedge sys_clk) awvalid <= 1'b0;
      end
      begin
        do @(negedge sys_clk); while (wready !== 1'b1);
        @(posedge sys_clk) wvalid <= 1'b0;
      end
    join
    do @(negedge sys_clk); while (bvalid !== 1'b1);
    last_resp = bresp;
    @(posedge sys_clk) bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [3:0] a);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge sys_clk); while (arready !== 1'b1);
    @(posedge sys_clk) arvalid <= 1'b0;
    do @(negedge sys_clk); while (rvalid !== 1'b1);
    rd_word = rdata;
    last_resp = rresp;
    @(posedge sys_clk) rready <= 1'b0;
  endtask
  // Command, then poll busy; leaves the last status byte in rd_word
  task automatic run_cmd(input logic [31:0] c);
    axi_wr(MRR_C_CMD, c);
    do axi_rd(MRR_C_STATUS); while (rd_word[8] !== 1'b0);
  endtask
  task automatic link_wr(input logic [7:0] a, input logic [7:0] d);
    run_cmd({8'h00, d, 8'h05, a});
  endtask
  task automatic expect_reg(input logic [7:0] a, input logic [7:0] e);
    run_cmd({16'h0000, 8'h01, a});
    axi_rd(MRR_C_DATA);
    check($sformatf("register %h", a), rd_word[23:16], e);
  endtask
  task automatic read_cycle();
    run_cmd(32'h0000_0300);
    st = rd_word[7:0];
    axi_rd(MRR_C_DATA);
    xy = rd_word[15:0];
  endtask
  task automatic move(input logic signed [7:0] x, input logic signed [7:0] y);
    @(posedge sys_clk);
    move_x <= x;
    move_y <= y;
    move_valid <= 1'b1;
    @(posedge sys_clk) move_valid <= 1'b0;
  endtask
  task automatic frame(input logic [9:0] f, input logic [15:0] s, input logic [5:0] p);
    @(posedge sys_clk);
    frame_features <= f;
    frame_sum <= s;
    frame_peak <= p;
    frame_done <= 1'b1;
    @(posedge sys_clk) frame_done <= 1'b0;
  endtask

  // ---------
  // Scenarios
  // ---------
  task automatic t_reset_values();
    expect_reg(MRR_ADDR_SETUP, 8'h09);
    expect_reg(MRR_ADDR_STATUS, 8'h00);
    for (int a = 3; a <= 7; a++) expect_reg(8'(a), 8'h00);
  endtask
  // Bit 7 and the low nibble must refuse the write
  task automatic t_setup();
    link_wr(MRR_ADDR_SETUP, 8'hff);
    expect_reg(MRR_ADDR_SETUP, 8'h79);
    check("led shutter", led_shutter, 1'b1);
    check("self test pulses", test_pulses, 1);
    expect_reg(MRR_ADDR_STATUS, 8'h01);
    link_wr(MRR_ADDR_SETUP, 8'h00);
    expect_reg(MRR_ADDR_SETUP, 8'h09);
    check("led shutter off", led_shutter, 1'b0);
    check("no extra test pulse", test_pulses, 1);
  endtask
  task automatic t_snapshot();
    move(8'sd5, -8'sd3);
    read_cycle();
    check("status byte", st, 8'h80);
    check("x and y", xy, 16'hfd05);
    expect_reg(MRR_ADDR_HDISP, 8'h00);
    expect_reg(MRR_ADDR_VDISP, 8'h00);
    expect_reg(MRR_ADDR_STATUS, 8'h00);
  endtask
  // Motion arriving after the status read must not leak into the snapshot
  task automatic t_freeze();
    move(8'sd4, 8'sd2);
    expect_reg(MRR_ADDR_STATUS, 8'h80);
    move(8'sd1, 8'sd1);
    expect_reg(MRR_ADDR_HDISP, 8'h04);
    expect_reg(MRR_ADDR_VDISP, 8'h02);
    expect_reg(MRR_ADDR_STATUS, 8'h80);
    move(8'sd2, 8'sd2);
    expect_reg(MRR_ADDR_STATUS, 8'h80);
    expect_reg(MRR_ADDR_HDISP, 8'h02);
    expect_reg(MRR_ADDR_VDISP, 8'h02);
  endtask
  task automatic t_overflow();
    logic [7:0]  exp_st [3] = '{8'h90, 8'h80, 8'h80};
    logic [15:0] exp_xy [3] = '{16'h007f, 16'h007f, 16'h0001};
    repeat (3) move(8'sd127, 8'sd0);
    for (int i = 0; i < 3; i++) begin
      read_cycle();
      check("drain status", st, exp_st[i]);
      check("drain x and y", xy, exp_xy[i]);
    end
    expect_reg(MRR_ADDR_STATUS, 8'h00);
  endtask
  task automatic t_flush();
    repeat (3) move(8'sh80, 8'sh80);
    expect_reg(MRR_ADDR_STATUS, 8'h90);
    link_wr(MRR_ADDR_FLUSH, 8'h5a);
    expect_reg(MRR_ADDR_STATUS, 8'h00);
    expect_reg(MRR_ADDR_HDISP, 8'h00);
  endtask
  task automatic t_frame();
    frame(10'h3ff, 16'hffff, 6'h3f);
    expect_reg(MRR_ADDR_FEATURE, 8'ha9);
    expect_reg(MRR_ADDR_BRIGHT, 8'hdd);
    expect_reg(MRR_ADDR_PEAK, 8'h3f);
    frame(10'h003, 16'h1234, 6'h05);
    expect_reg(MRR_ADDR_FEATURE, 8'h00);
    expect_reg(MRR_ADDR_BRIGHT, 8'h12);
    expect_reg(MRR_ADDR_PEAK, 8'h05);
  endtask
  task automatic t_unmapped();
    axi_rd(4'hc);
    check("unmapped read response", last_resp, MRR_RESP_ERR);
    axi_wr(4'hc, 32'h0000_0000);
    check("unmapped write response", last_resp, MRR_RESP_ERR);
    axi_wr(MRR_C_CMD, 32'h0000_0000);
    check("idle command response", last_resp, MRR_RESP_OK);
    expect_reg(8'h08, 8'h00);
  endtask

  // -------------------
  // Sequence and verdict
  // -------------------
  task automatic final_report();
    if (n_errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    reset = 1'b1;
    {move_valid, frame_done, awvalid, wvalid, bready, arvalid, rready} = '0;
    {move_x, move_y, frame_features, frame_sum, frame_peak} = '0;
    {awaddr, araddr, wdata} = '0;
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    t_reset_values();
    t_setup();
    t_snapshot();
    t_freeze();
    t_overflow();
    t_flush();
    t_frame();
    t_unmapped();
    final_report();
  end
  // Whole run needs under a thousand cycles; this allows 30000, over thirty times that
  initial begin
    #300000;
    n_errors++;
    final_report();
  end
endmodule // motion_report_readout_tb

// >>> testbench/mrr_link_assertions.sv
// Assertions on the register link between the readout device and its controller
`timescale 1ns/10ps
module mrr_link_assertions
  import mrr_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic       req,
  input  wire logic       write,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       ack,
  input  wire logic [7:0] rdata
);
  // ------------------------------------------------
  // Which register the answer on this cycle belongs to
  // ------------------------------------------------
  logic       rd_reg;
  logic [7:0] addr_reg;
  always_ff @(posedge sys_clk) begin
    rd_reg   <= req && !write;
    addr_reg <= addr;
  end
  // Read answers per register; a write answers with no data
  wire rd_st = ack && rd_reg && (addr_reg == MRR_ADDR_STATUS);
  wire rd_ft = ack && rd_reg && (addr_reg == MRR_ADDR_FEATURE);
  wire rd_br = ack && rd_reg && (addr_reg == MRR_ADDR_BRIGHT);
  wire rd_pk = ack && rd_reg && (addr_reg == MRR_ADDR_PEAK);
  wire rd_su = ack && rd_reg && (addr_reg == MRR_ADDR_SETUP);

  // ----------
  // Properties
  // ----------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  chk_ack_follows: assert property (req |=> ack) // link timing
    else $error("link answer missing one cycle after request");
  chk_ack_has_cause: assert property (ack |-> $past(req)) // link timing
    else $error("link answer without a request");
  chk_write_no_data: assert property (ack && !rd_reg |-> rdata == 8'h00) // link answer data
    else $error("write answer carries data");
  chk_status_layout: assert property (rd_st |-> (rdata & 8'h6e) == 8'h00)
    else $error("status reserved bits set");
  chk_feature_max: assert property (rd_ft |-> rdata <= 8'd169)
    else $error("feature count above limit");
  chk_bright_max: assert property (rd_br |-> rdata <= MRR_BRIGHT_MAX)
    else $error("brightness total above limit");
  chk_peak_six_bits: assert property (rd_pk |-> rdata[7:6] == 2'b00)
    else $error("peak brightness upper bits set");
  chk_setup_fixed: assert property (rd_su |-> (rdata & 8'h8f) == MRR_SETUP_RESET)
    else $error("setup fixed bits wrong");
endmodule // mrr_link_assertions
